// ===== hw/dram_powerup_reset_sequencer.sv
`timescale 1ns/1ps
`include "pwrseq_defines.svh"
// Summary of operation
// - finish self-init within 150 us, then ready
// - host keeps select high during power-up init; a hardware reset request cuts it to 400 ns from reset fall
// - init count waits while reset input low
// - refresh whole array during init time
// - host issues no transactions before init elapses; after a hardware reset the host allows them without waiting for init
// - reset low returns device to standby
// - reset restores configuration register defaults
// - reset stops refresh, clears row counter
// - reset forces exit from deep power down
// - host holds reset low at least 200 ns
// - host waits 200 ns after reset high
// - 400 ns from reset fall to select
// - host treats array as lost after reset
module dram_powerup_reset_sequencer
    import pwrseq_pkg::*;
#(
    parameter int INIT_CYCLES = `POWER_UP_INIT_CYC
)(
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    pwrseq_if.device             link,
    input  wire logic            i_dpd_enter,
    input  wire logic            i_cfg_we,
    input  wire logic [15:0]     i_cfg_wdata,
    output logic                 o_ready,
    output logic                 o_refresh_active,
    output logic [`ROW_W-1:0]    o_refresh_row,
    output logic [15:0]          o_cfg,
    output logic                 o_deep_pd
);
    // i_rst models supply coming up; link.reset_n is the hardware reset

    dev_state_t              state_r;    // sequencing state
    dev_state_t              state_nxt;
    logic [`INIT_CNT_W-1:0]  init_cnt_r; // cycles spent in init
    logic [`INIT_CNT_W-1:0]  init_cnt_nxt;
    logic [`ROW_W-1:0]       row_r;      // self-refresh row counter
    logic [`ROW_W-1:0]       row_nxt;
    logic [15:0]             cfg_r;      // configuration register
    logic [15:0]             cfg_nxt;
    logic                    init_done;

    // init window ends at the parameterised count
    assign init_done = (init_cnt_r == `INIT_CNT_W'(INIT_CYCLES - 1));

    // next state and counters
    always_comb
    begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        row_nxt      = row_r;
        cfg_nxt      = cfg_r;
        if (!link.reset_n)
        begin
            // reset low: standby, defaults, refresh halted, leave pd
            state_nxt    = DEV_RESET_HELD;
            cfg_nxt      = `CFG_DEFAULT;
            row_nxt      = '0;
            init_cnt_nxt = '0;
        end
        else
        begin
            case (state_r)
                DEV_RESET_HELD:
                begin
                    // reset released: start init timing now
                    state_nxt    = DEV_INIT;
                    init_cnt_nxt = '0;
                end
                DEV_INIT:
                begin
                    // array refresh runs throughout the init window
                    row_nxt      = row_r + `ROW_W'(1);
                    init_cnt_nxt = init_cnt_r + `INIT_CNT_W'(1);
                    if (init_done)
                        state_nxt = DEV_READY;
                end
                DEV_READY:
                begin
                    // self-refresh resumes; one row per cycle is a
                    // simple stand-in for the real refresh cadence
                    row_nxt = row_r + `ROW_W'(1);
                    if (i_cfg_we && link.select_n)
                        cfg_nxt = i_cfg_wdata;
                    if (i_dpd_enter && link.select_n)
                        state_nxt = DEV_DEEP_PD;
                end
                DEV_DEEP_PD:
                begin
                    // only a hardware reset leaves this state
                    state_nxt = DEV_DEEP_PD;
                end
                default:
                    state_nxt = DEV_RESET_HELD;
            endcase
        end
    end

    // registers: supply reset puts device in reset-held, one edge before init
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r    <= DEV_RESET_HELD;
            init_cnt_r <= '0;
            row_r      <= '0;
            cfg_r      <= `CFG_DEFAULT;
        end
        else
        begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            row_r      <= row_nxt;
            cfg_r      <= cfg_nxt;
        end
    end

    // status outputs: ready, refresh and deep pd decoded from registered state; row and cfg pass straight through
    assign o_ready          = (state_r == DEV_READY);
    assign o_refresh_active = (state_r == DEV_INIT) ||
                              (state_r == DEV_READY);
    assign o_refresh_row    = row_r;
    assign o_cfg            = cfg_r;
    assign o_deep_pd        = (state_r == DEV_DEEP_PD);
endmodule // dram_powerup_reset_sequencer

// ===== hw/pwrseq_defines.svh
`ifndef PWRSEQ_DEFINES_SVH
`define PWRSEQ_DEFINES_SVH

// clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS          5000
// timing figures in their own units
`define POWER_UP_INIT_TIME_US  150
`define RESET_PULSE_WIDTH_NS   200
`define RESET_HIGH_TO_SELECT_NS 200
`define RESET_LOW_TO_SELECT_NS 400
// derived cycle counts: least times round up, longest rounds down
`define POWER_UP_INIT_CYC  ((`POWER_UP_INIT_TIME_US*1000000)/`CLK_PERIOD_PS)
`define RESET_PULSE_CYC \
    ((`RESET_PULSE_WIDTH_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define RESET_HIGH_SEL_CYC \
    ((`RESET_HIGH_TO_SELECT_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define RESET_LOW_SEL_CYC \
    ((`RESET_LOW_TO_SELECT_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
// counter widths
`define INIT_CNT_W   16
`define HOST_CNT_W   8
`define ROW_W        13
// configuration register default value
`define CFG_DEFAULT  16'h8F1F

`endif

// ===== hw/pwrseq_pkg.sv
package pwrseq_pkg;
    // device-side sequencing states
    typedef enum logic [2:0] {
        DEV_RESET_HELD,
        DEV_INIT,
        DEV_READY,
        DEV_DEEP_PD
    } dev_state_t;
    // host-side sequencing states
    typedef enum logic [2:0] {
        HST_PWRUP,
        HST_RST_LOW,
        HST_RST_HIGH_WAIT,
        HST_READY
    } host_state_t;
endpackage

// ===== hw/pwrseq_if.sv
`timescale 1ns/1ps
// link between host controller and memory device sequencer
interface pwrseq_if;
    logic reset_n;   // hardware reset, active low, host drives
    logic select_n;  // chip select, active low, host drives
    modport host   (output reset_n, output select_n);
    modport device (input reset_n, input select_n);
endinterface

// ===== hw/dram_host_reset_ctrl.sv
`timescale 1ns/1ps
`include "pwrseq_defines.svh"
// host end: drives reset and gates chip select by the timing rules
module dram_host_reset_ctrl
    import pwrseq_pkg::*;
#(
    parameter int INIT_CYCLES = `POWER_UP_INIT_CYC
)(
    input  wire logic i_clk,
    input  wire logic i_rst,
    pwrseq_if.host    link,
    input  wire logic i_hw_reset_req,  // pulse: start a hardware reset
    input  wire logic i_select_req,    // level: user wants the bus
    output logic      o_bus_ok,        // transactions allowed
    output logic      o_data_lost      // sticky, cleared by select
);
    host_state_t             state_r;
    host_state_t             state_nxt;
    logic [`INIT_CNT_W-1:0]  cnt_r;     // general wait counter
    logic [`INIT_CNT_W-1:0]  cnt_nxt;
    logic [`HOST_CNT_W-1:0]  low_r;     // cycles since reset fell
    logic [`HOST_CNT_W-1:0]  low_nxt;
    logic                    lost_r;
    logic                    lost_nxt;
    logic                    rst_n_r;
    logic                    rst_n_nxt;

    // next values
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + `INIT_CNT_W'(1);
        low_nxt   = (low_r == '1) ? low_r : low_r + `HOST_CNT_W'(1);
        lost_nxt  = lost_r;
        rst_n_nxt = rst_n_r;
        case (state_r)
            HST_PWRUP:
            begin
                // select held high through the init window; the device
                // spends one extra edge leaving reset-held, so wait it out
                if (cnt_r == `INIT_CNT_W'(INIT_CYCLES))
                    state_nxt = HST_READY;
            end
            HST_RST_LOW:
            begin
                // reset pulse held for the minimum width
                if (cnt_r == `INIT_CNT_W'(`RESET_PULSE_CYC - 1))
                begin
                    rst_n_nxt = 1'b1;
                    state_nxt = HST_RST_HIGH_WAIT;
                    cnt_nxt   = '0;
                end
            end
            HST_RST_HIGH_WAIT:
            begin
                // both release gap and fall-to-select gap must pass
                if (cnt_r >= `INIT_CNT_W'(`RESET_HIGH_SEL_CYC - 1) &&
                    low_r >= `HOST_CNT_W'(`RESET_LOW_SEL_CYC - 1))
                    state_nxt = HST_READY;
            end
            HST_READY:
            begin
                if (i_select_req)
                    lost_nxt = 1'b0;
                cnt_nxt = cnt_r;
            end
            default:
                state_nxt = HST_PWRUP;
        endcase
        // reset request wins from any state but HST_RST_LOW, ending any current select at the next clock edge
        if (i_hw_reset_req && !(state_r == HST_RST_LOW))
        begin
            state_nxt = HST_RST_LOW;
            rst_n_nxt = 1'b0;
            cnt_nxt   = '0;
            low_nxt   = '0;
            lost_nxt  = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= HST_PWRUP;
            cnt_r   <= '0;
            low_r   <= '0;
            lost_r  <= 1'b0;
            rst_n_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            low_r   <= low_nxt;
            lost_r  <= lost_nxt;
            rst_n_r <= rst_n_nxt;
        end
    end

    assign o_bus_ok      = (state_r == HST_READY);
    assign o_data_lost   = lost_r;
    assign link.reset_n  = rst_n_r;
    // select only driven low when timing allows
    assign link.select_n = !(o_bus_ok && i_select_req);
endmodule // dram_host_reset_ctrl

// ===== test/pwrseq_monitor.sv
`timescale 1ns/1ps
`include "pwrseq_defines.svh"
// watches the link wires and both ends' outputs
module pwrseq_monitor #(
    parameter int INIT_CYCLES = 50
)(
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire logic              reset_n,
    input wire logic              select_n,
    input wire logic              o_ready,
    input wire logic              o_refresh_active,
    input wire logic [`ROW_W-1:0] o_refresh_row,
    input wire logic [15:0]       o_cfg,
    input wire logic              o_deep_pd,
    input wire logic              o_bus_ok,
    input wire logic              o_data_lost
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // host reset pulse is exactly 40 cycles low
    sequence s_pulse;
        ##39 !reset_n ##1 reset_n;
    endsequence
    // device counts its init time, then reports ready
    sequence s_init;
        (!o_ready throughout (##INIT_CYCLES 1'b1)) ##1 o_ready;
    endsequence
    a_reset_pulse_width: assert property ($fell(reset_n) |-> s_pulse)
        else $error("reset pulse width wrong");
    a_high_to_select: assert property
        ($rose(reset_n) |-> select_n throughout (##39 1'b1))
        else $error("select too soon after reset high");
    a_low_to_select: assert property
        ($fell(reset_n) |-> select_n throughout (##79 1'b1))
        else $error("select too soon after reset low");
    a_init_no_select: assert property (!o_bus_ok |-> select_n)
        else $error("select while bus not allowed");
    a_ready_timing: assert property ($rose(reset_n) |-> s_init)
        else $error("ready timing wrong");
    a_reset_standby: assert property
        (!reset_n |=> !o_ready && !o_deep_pd && !o_refresh_active)
        else $error("not in standby during reset");
    a_row_cleared: assert property (!reset_n |=> o_refresh_row == '0)
        else $error("row counter not cleared");
    a_cfg_default: assert property (!reset_n |=> o_cfg == `CFG_DEFAULT)
        else $error("config not defaulted");
    a_refresh_resume: assert property ($rose(reset_n) |=> o_refresh_active)
        else $error("refresh not resumed");
    a_data_lost: assert property ($fell(reset_n) |-> o_data_lost)
        else $error("data lost flag missing");
endmodule // pwrseq_monitor

// ===== test/test_dram_powerup_reset_sequencer.sv
`timescale 1ns/1ps
`include "pwrseq_defines.svh"
`define CHK(g, e) check(16'(g), 16'(e))
module test_dram_powerup_reset_sequencer;
    import pwrseq_pkg::*;
    localparam int INIT = 50;  // shortened init count
    typedef struct {logic sel; logic [15:0] wd; logic [15:0] ex;} row_t;
    // cfg writes: refused while selected
    row_t rows [3] = '{'{0, 16'h1234, 16'h1234}, '{1, 16'hABCD, 16'h1234},
                       '{0, 16'h5A5A, 16'h5A5A}};
    logic clk = 0, host_rst = 1, dev_rst = 1, hw_req = 0, sel_req = 0;
    logic deep_power_down = 0, we = 0, ready, ref_act, dpd_o, bus_ok, lost;
    logic [15:0] wdata = '0, cfg;
    logic [`ROW_W-1:0] row;
    int errors = 0, comparisons = 0, n;
    pwrseq_if pwrseq_if_i ();
    dram_powerup_reset_sequencer #(.INIT_CYCLES(INIT))
        dram_powerup_reset_sequencer_i (.i_clk(clk), .i_rst(dev_rst),
        .link(pwrseq_if_i), .i_dpd_enter(deep_power_down), .i_cfg_we(we),
        .i_cfg_wdata(wdata), .o_ready(ready), .o_refresh_active(ref_act),
        .o_refresh_row(row), .o_cfg(cfg), .o_deep_pd(dpd_o));
    dram_host_reset_ctrl #(.INIT_CYCLES(INIT)) dram_host_reset_ctrl_i (
        .i_clk(clk), .i_rst(host_rst), .link(pwrseq_if_i),
        .i_hw_reset_req(hw_req), .i_select_req(sel_req),
        .o_bus_ok(bus_ok), .o_data_lost(lost));
    pwrseq_monitor #(.INIT_CYCLES(INIT)) pwrseq_monitor_i (.i_clk(clk),
        .i_rst(host_rst), .reset_n(pwrseq_if_i.reset_n),
        .select_n(pwrseq_if_i.select_n), .o_ready(ready),
        .o_refresh_active(ref_act), .o_refresh_row(row), .o_cfg(cfg),
        .o_deep_pd(dpd_o), .o_bus_ok(bus_ok), .o_data_lost(lost));
    always #2.5 clk = ~clk;
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bounded wait on ready (0) or bus_ok (1), counts cycles
    task automatic wait_sig(input logic which, output int c);
        c = 0;
        while ((which ? bus_ok : ready) !== 1'b1 && c < 500)
        begin
            @(negedge clk);
            c++;
        end
        if (c == 500)
        begin
            errors++;
            finish_test();
        end
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        host_rst = 0;
        dev_rst = 0;
        wait_sig(0, n);
        `CHK(n <= INIT + 2, 1);
        $display("test power_up done");
        foreach (rows[i])
        begin
            sel_req = rows[i].sel;
            @(negedge clk);
            we = 1;
            wdata = rows[i].wd;
            @(negedge clk);
            we = 0;
            sel_req = 0;
            @(negedge clk);
            `CHK(cfg, rows[i].ex);
        end
        $display("test cfg_rows done");
        deep_power_down = 1;
        @(negedge clk);
        deep_power_down = 0;
        @(negedge clk);
        `CHK(dpd_o, 1);
        hw_req = 1;
        @(negedge clk);
        hw_req = 0;
        repeat (2) @(negedge clk);
        `CHK(dpd_o, 0);
        `CHK(cfg, `CFG_DEFAULT);
        `CHK(lost, 1);
        wait_sig(1, n);
        `CHK(n + 2 >= `RESET_LOW_SEL_CYC, 1);
        wait_sig(0, n);
        sel_req = 1;
        @(negedge clk);
        `CHK(pwrseq_if_i.select_n, 0);
        `CHK(lost, 0);
        sel_req = 0;
        $display("test hw_reset done");
        hw_req = 1;
        @(negedge clk);
        hw_req = 0;
        repeat (5) @(negedge clk);
        dev_rst = 1;
        @(negedge clk);
        dev_rst = 0;
        repeat (10) @(negedge clk);
        `CHK(ready, 0);
        `CHK(ref_act, 0);
        wait_sig(0, n);
        `CHK(n > INIT + 20, 1);
        `CHK(ref_act, 1);
        $display("test reset_during_power_up done");
        finish_test();
    end
endmodule // test_dram_powerup_reset_sequencer
